// File: mtl_terminal.sv
// Functional notes
// - down input lowers set frequency steadily, stopping at minimum frequency
// - up/down changes not stored; restart uses stored primary frequency
// - coast input removes drive output at once, no ramp
// - fault-reset input clears alarm like the panel reset key
// - pid contact enables pid; mode 2 means off while open
// - sequencer-enable contact starts the program sequencer
// - timer start inputs count while closed; preset drives output
// - counter pulse input counts pulses; source keeps below 250 Hz
// - counter-clear input zeroes the accumulated count
// - sequencer position kept over stop; memory-clear restarts at step one
// - winding input starts winding; done output held until drive stops
// - three outputs take codes 0-63, defaults 1,2,3; 0 is off
// - running output on while drive delivers output
// - frequency reached outputs on when frequency meets set values
// - fault output on while a fault or bus undervoltage is detected
// - zero-speed output on below start-up frequency
// - accelerating and decelerating outputs follow ramp direction
// - undervoltage output and alarm when bus below threshold
// - timer-reached outputs on at preset, off when start released
// - stage-done pulse per step, process-done pulse at program end
// - pid upper and lower limit outputs follow feedback
// - count-reached and middle-count-reached outputs at their presets
// - count at preset drives output; reset restarts from zero
`timescale 1ns/1ps
`default_nettype none
`include "mtl_cfg.svh"
module mtl_terminal #(
    parameter int TICK_CYC = `MTL_TICK_NS / `MTL_CLK_NS,
    parameter int RAMP_CYC = `MTL_RAMP_NS / `MTL_CLK_NS
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [`MTL_N_IN-1:0] i_term,
    input wire mtl_pkg::mtl_addr_t i_addr,
    input wire mtl_pkg::mtl_word_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire mtl_pkg::mtl_word_t i_out_freq,
    input wire mtl_pkg::mtl_word_t i_dc_bus,
    input wire mtl_pkg::mtl_word_t i_pid_fb,
    input wire logic i_running,
    input wire logic i_accel,
    input wire logic i_decel,
    input wire logic i_fault_det,
    input wire logic i_overload,
    input wire logic i_over_torque,
    input wire logic i_loop_open,
    input wire logic i_panel_reset,
    input wire logic i_seq_step_done,
    input wire logic i_wind_complete,
    output mtl_pkg::mtl_word_t o_rdata,
    output mtl_pkg::mtl_word_t o_set_freq,
    output logic o_coast,
    output logic o_fault_reset,
    output logic o_pid_en,
    output logic o_seq_run,
    output logic [7:0] o_seq_pos,
    output logic o_wind_en,
    output logic o_wind_hold,
    output logic o_uv_alarm,
    output logic [`MTL_N_OUT-1:0] o_out_term
);
    import mtl_pkg::*;

    mtl_term_if #(.N(`MTL_N_IN)) term ();
    mtl_word_t cfg_ff [`MTL_N_CFG];
    mtl_word_t rdata_ff, set_freq_ff, count_ff, nxt_set_freq;
    mtl_word_t tmr_ff [2];
    logic [31:0] tick_ff, ramp_ff;
    logic [7:0] pos_ff;
    logic [`MTL_N_OUT-1:0] out_ff;
    logic coast_ff, freset_ff, pid_ff, seq_ff, wen_ff, uv_ff;
    logic stage_ff, proc_ff;
    mtl_wind_t wind_ff;
    logic [63:0] flags;
    logic tick, ramp, up, down;

    mtl_in_filter u_filt (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pins(i_term),
        .term(term.src)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic hit(input logic [`MTL_N_IN-1:0] v,
                                 input mtl_code_t code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < `MTL_N_IN; i++) begin
            if (v[i] && cfg_ff[i][5:0] == code) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic mtl_word_t cfg_rst(input int idx);
        case (idx)
            6: return `MTL_RST_OUT0;
            7: return `MTL_RST_OUT1;
            8: return `MTL_RST_OUT2;
            9: return `MTL_RST_PRIMARY;
            11: return `MTL_RST_FMAX;
            17: return `MTL_RST_CNT_PRE;
            18: return `MTL_RST_CNT_MID;
            21: return `MTL_RST_SEQ_STEPS;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic mtl_word_t cfg(input mtl_addr_t a);
        return cfg_ff[a[4:0]];
    endfunction

    assign up = hit(term.lvl, `MTL_IN_UP);
    assign down = hit(term.lvl, `MTL_IN_DOWN);
    assign tick = (tick_ff == 32'(TICK_CYC - 1));
    assign ramp = (ramp_ff == 32'(RAMP_CYC - 1));

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            for (int i = 0; i < `MTL_N_CFG; i++) begin
                cfg_ff[i] <= cfg_rst(i);
            end
        end else if (i_wr && i_addr < 8'(`MTL_N_CFG)) begin
            cfg_ff[i_addr[4:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_ff <= '0;
        end else if (!i_rd) begin
            rdata_ff <= '0;
        end else if (i_addr < 8'(`MTL_N_CFG)) begin
            rdata_ff <= cfg_ff[i_addr[4:0]];
        end else begin
            case (i_addr)
                `MTL_A_SET_FREQ: rdata_ff <= set_freq_ff;
                `MTL_A_COUNT: rdata_ff <= count_ff;
                `MTL_A_SEQ_POS: rdata_ff <= {8'h00, pos_ff};
                `MTL_A_STATUS: rdata_ff <= {4'h0, 1'b0, out_ff,
                                            2'h0, term.lvl};
                default: rdata_ff <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // time bases
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tick_ff <= '0;
            ramp_ff <= '0;
        end else begin
            tick_ff <= tick ? 32'h0 : tick_ff + 32'h1;
            ramp_ff <= ramp ? 32'h0 : ramp_ff + 32'h1;
        end
    end

    // ----------------------------------------
    // frequency trim
    // ----------------------------------------
    always_comb begin
        nxt_set_freq = set_freq_ff;
        if (i_wr && i_addr == `MTL_A_PRIMARY) begin
            nxt_set_freq = i_wdata;
        end else if (wind_ff == MTL_WIND_DONE) begin
            nxt_set_freq = set_freq_ff;
        end else if (ramp && up && !down) begin
            if (set_freq_ff < cfg(`MTL_A_FMAX)) begin
                nxt_set_freq = set_freq_ff + 16'h0001;
            end
        end else if (ramp && down && !up) begin
            if (set_freq_ff > cfg(`MTL_A_FMIN)) begin
                nxt_set_freq = set_freq_ff - 16'h0001;
            end
        end
    end

    // trimmed value lives only here; reset reloads the primary default
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            set_freq_ff <= `MTL_RST_PRIMARY;
        end else begin
            set_freq_ff <= nxt_set_freq;
        end
    end

    // ----------------------------------------
    // direct input functions
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            coast_ff <= 1'b0;
            freset_ff <= 1'b0;
            pid_ff <= 1'b0;
            seq_ff <= 1'b0;
            wen_ff <= 1'b0;
            uv_ff <= 1'b0;
        end else begin
            coast_ff <= hit(term.lvl, `MTL_IN_COAST);
            freset_ff <= hit(term.rise, `MTL_IN_FRESET) | i_panel_reset;
            pid_ff <= hit(term.lvl, `MTL_IN_PID) |
                      (cfg(`MTL_A_PID_MODE) == `MTL_PID_MODE_ALWAYS);
            seq_ff <= hit(term.lvl, `MTL_IN_SEQ);
            wen_ff <= hit(term.lvl, `MTL_IN_WIND);
            uv_ff <= (i_dc_bus < cfg(`MTL_A_UV_THR));
        end
    end

    // ----------------------------------------
    // timers
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tmr_ff[0] <= '0;
            tmr_ff[1] <= '0;
        end else begin
            for (int t = 0; t < 2; t++) begin
                if (!hit(term.lvl, 6'(`MTL_IN_TMR1 + t))) begin
                    tmr_ff[t] <= '0;
                end else if (tick && tmr_ff[t] != 16'hFFFF) begin
                    tmr_ff[t] <= tmr_ff[t] + 16'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // pulse counter
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_ff <= '0;
        end else if (hit(term.lvl, `MTL_IN_CCLR)) begin
            count_ff <= '0;
        end else if (hit(term.rise, `MTL_IN_CPULSE) &&
                     count_ff != 16'hFFFF) begin
            count_ff <= count_ff + 16'h0001;
        end
    end

    // ----------------------------------------
    // program sequencer
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pos_ff <= '0;
            stage_ff <= 1'b0;
            proc_ff <= 1'b0;
        end else begin
            stage_ff <= 1'b0;
            proc_ff <= 1'b0;
            if (hit(term.lvl, `MTL_IN_MCLR)) begin
                pos_ff <= '0;
            end else if (seq_ff && i_seq_step_done) begin
                stage_ff <= 1'b1;
                if (16'(pos_ff) + 16'h0001 >= cfg(`MTL_A_SEQ_STEPS)) begin
                    pos_ff <= '0;
                    proc_ff <= 1'b1;
                end else begin
                    pos_ff <= pos_ff + 8'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // winding
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wind_ff <= MTL_WIND_IDLE;
        end else begin
            case (wind_ff)
                MTL_WIND_IDLE: begin
                    if (wen_ff) begin
                        wind_ff <= MTL_WIND_ACTIVE;
                    end
                end
                MTL_WIND_ACTIVE: begin
                    if (i_wind_complete) begin
                        wind_ff <= MTL_WIND_DONE;
                    end else if (!wen_ff) begin
                        wind_ff <= MTL_WIND_IDLE;
                    end
                end
                MTL_WIND_DONE: begin
                    if (!i_running) begin
                        wind_ff <= MTL_WIND_IDLE;
                    end
                end
                default: wind_ff <= MTL_WIND_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // output selection
    // ----------------------------------------
    always_comb begin
        flags = '0;
        flags[1] = i_running;
        flags[2] = (i_out_freq == set_freq_ff);
        flags[3] = i_fault_det | uv_ff;
        flags[4] = (i_out_freq < cfg(`MTL_A_FSTART));
        flags[5] = (i_out_freq == cfg(`MTL_A_FREQ1));
        flags[6] = (i_out_freq == cfg(`MTL_A_FREQ2));
        flags[7] = i_accel;
        flags[8] = i_decel;
        flags[9] = uv_ff;
        flags[10] = (tmr_ff[0] >= cfg(`MTL_A_TMR1)) && 
                    hit(term.lvl, `MTL_IN_TMR1);
        flags[11] = (tmr_ff[1] >= cfg(`MTL_A_TMR2)) &&
                    hit(term.lvl, `MTL_IN_TMR2);
        flags[12] = stage_ff;
        flags[13] = proc_ff;
        flags[14] = (i_pid_fb > cfg(`MTL_A_PID_HI));
        flags[15] = (i_pid_fb < cfg(`MTL_A_PID_LO));
        flags[16] = i_loop_open;
        flags[17] = i_overload;
        flags[18] = i_over_torque;
        flags[26] = (wind_ff == MTL_WIND_DONE);
        flags[27] = (count_ff == cfg(`MTL_A_CNT_PRE));
        flags[28] = (count_ff == cfg(`MTL_A_CNT_MID));
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            out_ff <= '0;
        end else begin
            for (int k = 0; k < `MTL_N_OUT; k++) begin
                out_ff[k] <= flags[cfg_ff[6 + k][5:0]];
            end
        end
    end

    assign o_rdata = rdata_ff;
    assign o_set_freq = set_freq_ff;
    assign o_coast = coast_ff;
    assign o_fault_reset = freset_ff;
    assign o_pid_en = pid_ff;
    assign o_seq_run = seq_ff;
    assign o_seq_pos = pos_ff;
    assign o_wind_en = wen_ff;
    assign o_wind_hold = wind_ff[1];
    assign o_uv_alarm = uv_ff;
    assign o_out_term = out_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_coast_at_once: assert property (
        hit(term.lvl, `MTL_IN_COAST) |=> o_coast)
        else $error("coast not applied next cycle");
    a_code_zero_off: assert property (
        cfg_ff[8][5:0] == 6'h00 && $stable(cfg_ff[8]) |=> !o_out_term[2])
        else $error("unassigned output is active");
    a_count_clear: assert property (
        hit(term.lvl, `MTL_IN_CCLR) |=> count_ff == 16'h0000)
        else $error("count not cleared");
    a_count_step: assert property (
        !hit(term.lvl, `MTL_IN_CCLR) && hit(term.rise, `MTL_IN_CPULSE) &&
        count_ff < 16'hFFFF |=> count_ff == $past(count_ff) + 16'h0001)
        else $error("pulse not counted");
    a_timer_release: assert property (
        !hit(term.lvl, `MTL_IN_TMR1) |=> tmr_ff[0] == 16'h0000)
        else $error("timer not reset on release");
    a_wind_clear: assert property (
        wind_ff == MTL_WIND_DONE && !i_running |=> !o_wind_hold)
        else $error("winding done kept after stop");
    a_stage_pulse: assert property (
        o_seq_run && i_seq_step_done && !hit(term.lvl, `MTL_IN_MCLR)
        |=> stage_ff ##1 !stage_ff || $past(i_seq_step_done))
        else $error("stage pulse missing");
    a_down_floor: assert property (
        set_freq_ff >= cfg(`MTL_A_FMIN) && down && !up &&
        !(i_wr && i_addr == `MTL_A_PRIMARY) |=> 
        set_freq_ff >= $past(cfg(`MTL_A_FMIN)))
        else $error("set frequency below floor");
    a_mem_clear: assert property (
        hit(term.lvl, `MTL_IN_MCLR) |=> pos_ff == 8'h00)
        else $error("sequencer not reset");
    a_uv_alarm: assert property (
        i_dc_bus < cfg(`MTL_A_UV_THR) |=> o_uv_alarm)
        else $error("undervoltage alarm missing");

    c_count_pulse: cover property (hit(term.rise, `MTL_IN_CPULSE));
    c_wind_done: cover property (wind_ff == MTL_WIND_DONE ##1 !o_wind_hold);
    c_proc_done: cover property (proc_ff);
    c_coast: cover property (o_coast);
endmodule
`default_nettype wire

// File: mtl_cfg.svh
`ifndef MTL_CFG_SVH
`define MTL_CFG_SVH

// ----------------------------------------
// widths, counts and time constants
// ----------------------------------------
`define MTL_N_IN 6
`define MTL_N_OUT 3
`define MTL_N_CFG 24
`define MTL_CLK_NS 25
`define MTL_FILT_NS 100000
`define MTL_FILT_CYC ((`MTL_FILT_NS + `MTL_CLK_NS - 1) / `MTL_CLK_NS)
`define MTL_TICK_NS 1000000
`define MTL_RAMP_NS 10000000

// ----------------------------------------
// input function codes
// ----------------------------------------
`define MTL_IN_DOWN 6'h10
`define MTL_IN_COAST 6'h11
`define MTL_IN_FRESET 6'h12
`define MTL_IN_PID 6'h13
`define MTL_IN_SEQ 6'h14
`define MTL_IN_TMR1 6'h15
`define MTL_IN_TMR2 6'h16
`define MTL_IN_CPULSE 6'h17
`define MTL_IN_CCLR 6'h18
`define MTL_IN_MCLR 6'h19
`define MTL_IN_WIND 6'h1A
`define MTL_IN_UP 6'h0F

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MTL_A_IN_SEL0 8'h00
`define MTL_A_OUT_SEL0 8'h06
`define MTL_A_PRIMARY 8'h09
`define MTL_A_FMIN 8'h0A
`define MTL_A_FMAX 8'h0B
`define MTL_A_FREQ1 8'h0C
`define MTL_A_FREQ2 8'h0D
`define MTL_A_FSTART 8'h0E
`define MTL_A_TMR1 8'h0F
`define MTL_A_TMR2 8'h10
`define MTL_A_CNT_PRE 8'h11
`define MTL_A_CNT_MID 8'h12
`define MTL_A_PID_MODE 8'h13
`define MTL_A_UV_THR 8'h14
`define MTL_A_SEQ_STEPS 8'h15
`define MTL_A_PID_HI 8'h16
`define MTL_A_PID_LO 8'h17
`define MTL_A_SET_FREQ 8'h20
`define MTL_A_COUNT 8'h21
`define MTL_A_SEQ_POS 8'h22
`define MTL_A_STATUS 8'h23

// ----------------------------------------
// reset values and pid mode codes
// ----------------------------------------
`define MTL_RST_OUT0 16'h0001
`define MTL_RST_OUT1 16'h0002
`define MTL_RST_OUT2 16'h0003
`define MTL_RST_PRIMARY 16'h1388
`define MTL_RST_FMAX 16'h1388
`define MTL_RST_CNT_PRE 16'h0064
`define MTL_RST_CNT_MID 16'h0032
`define MTL_RST_SEQ_STEPS 16'h0001
`define MTL_PID_MODE_CONTACT 16'h0002
`define MTL_PID_MODE_ALWAYS 16'h0001

`endif

// File: mtl_pkg.sv
package mtl_pkg;
    typedef logic [15:0] mtl_word_t;
    typedef logic [7:0] mtl_addr_t;
    typedef logic [5:0] mtl_code_t;
    typedef enum logic [1:0] {
        MTL_WIND_IDLE = 2'b00,
        MTL_WIND_ACTIVE = 2'b01,
        MTL_WIND_DONE = 2'b10
    } mtl_wind_t;
endpackage

// File: mtl_term_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mtl_term_if #(parameter int N = 6);
    logic [N-1:0] lvl;
    logic [N-1:0] rise;
    modport src (output lvl, output rise);
    modport dst (input lvl, input rise);
endinterface
`default_nettype wire

// File: mtl_in_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "mtl_cfg.svh"
module mtl_in_filter (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [`MTL_N_IN-1:0] i_pins,
    mtl_term_if.src term
);
    import mtl_pkg::*;

    localparam int FILT_CYC = `MTL_FILT_CYC;

    logic [`MTL_N_IN-1:0] s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff;
    logic [11:0] cnt_ff [`MTL_N_IN];

    // ----------------------------------------
    // three-stage synchroniser
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= i_pins;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // ----------------------------------------
    // debounce and edge detect
    // ----------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lvl_ff <= '0;
            rise_ff <= '0;
            for (int i = 0; i < `MTL_N_IN; i++) begin
                cnt_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `MTL_N_IN; i++) begin
                rise_ff[i] <= 1'b0;
                if (s2_ff[i] != s3_ff[i] || s3_ff[i] == lvl_ff[i]) begin
                    cnt_ff[i] <= '0;
                end else if (cnt_ff[i] == 12'(FILT_CYC - 1)) begin
                    cnt_ff[i] <= '0;
                    lvl_ff[i] <= s3_ff[i];
                    rise_ff[i] <= s3_ff[i];
                end else begin
                    cnt_ff[i] <= cnt_ff[i] + 12'h001;
                end
            end
        end
    end

    assign term.lvl = lvl_ff;
    assign term.rise = rise_ff;
endmodule
`default_nettype wire

// File: mtl_field_sw.sv
`timescale 1ns/1ps
`default_nettype none
module mtl_field_sw #(
    parameter int PW = 4100,
    parameter int PERIOD = 160000
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [4:0] i_close,
    input wire logic i_pulse,
    output logic [5:0] o_term
);
    logic [4:0] cont_ff;
    logic [17:0] cnt_ff;
    // ----------------------------------------
    // contacts and pulse source
    // ----------------------------------------
    // contacts held as levels, changed after an edge
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cont_ff <= 5'h00;
        end else begin
            cont_ff <= i_close;
        end
    end
    // one pulse per period, never above 250 Hz
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_ff <= 18'h00000;
        end else if (cnt_ff != 18'h00000) begin
            cnt_ff <= cnt_ff - 18'h00001;
        end else if (i_pulse) begin
            cnt_ff <= 18'(PERIOD);
        end
    end
    assign o_term = {cnt_ff > 18'(PERIOD - PW), cont_ff};
endmodule
`default_nettype wire

// File: multifunction_terminal_logic_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module multifunction_terminal_logic_tb_top;
    import mtl_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pls = 1'b0;
    logic pnl = 1'b0;
    logic [1:0] ev = 2'h0;
    logic [4:0] cls = 5'h00;
    logic [6:0] st = 7'h00;
    mtl_addr_t addr = 8'h00;
    mtl_word_t wd = 16'h0000;
    mtl_word_t frq = 16'h0180;
    mtl_word_t fb = 16'h0200;
    mtl_word_t dc = 16'h0300;
    wire logic [5:0] term;
    mtl_word_t rdata, setf;
    logic coast, frst, pid, seqr, wen, whold, uv;
    logic [7:0] spos;
    logic [2:0] ot;
    int fails = 0;
    int compares = 0;
    localparam logic [63:0] BASE = 64'h0000_0180_0200_0300;
    // code, status {run,fault,acc,dec,ovl,trq,loop}, freq, fb, bus
    localparam logic [63:0] TBL [14] = '{
        64'h0140_0180_0200_0300, 64'h0200_1388_0200_0300,
        64'h0320_0180_0200_0300, 64'h0400_0050_0200_0300,
        64'h0500_0200_0200_0300, 64'h0600_0250_0200_0300,
        64'h0710_0180_0200_0300, 64'h0808_0180_0200_0300,
        64'h0900_0180_0200_0100, 64'h0E00_0180_0400_0300,
        64'h0F00_0180_0050_0300, 64'h1001_0180_0200_0300,
        64'h1104_0180_0200_0300, 64'h1202_0180_0200_0300};

    initial begin
        forever #12.5 clk = ~clk;
    end

    mtl_field_sw mtl_field_sw_i (.i_sys_clk(clk), .i_nrst(nrst),
        .i_close(cls), .i_pulse(pls), .o_term(term));

    mtl_terminal #(.TICK_CYC(10), .RAMP_CYC(4)) mtl_terminal_i (
        .i_sys_clk(clk), .i_nrst(nrst), .i_term(term), .i_addr(addr),
        .i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_out_freq(frq),
        .i_dc_bus(dc), .i_pid_fb(fb), .i_running(st[6]),
        .i_fault_det(st[5]), .i_accel(st[4]), .i_decel(st[3]),
        .i_overload(st[2]), .i_over_torque(st[1]), .i_loop_open(st[0]),
        .i_panel_reset(pnl), .i_seq_step_done(ev[0]),
        .i_wind_complete(ev[1]), .o_rdata(rdata), .o_set_freq(setf),
        .o_coast(coast), .o_fault_reset(frst), .o_pid_en(pid),
        .o_seq_run(seqr), .o_seq_pos(spos), .o_wind_en(wen),
        .o_wind_hold(whold), .o_uv_alarm(uv), .o_out_term(ot));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input mtl_word_t got, input mtl_word_t exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input mtl_addr_t a, input mtl_word_t d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input mtl_addr_t a, input mtl_word_t e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task automatic setc(input logic [63:0] e);
        @(posedge clk);
        st <= e[54:48];
        frq <= e[47:32];
        fb <= e[31:16];
        dc <= e[15:0];
    endtask
    task automatic contact(input logic [4:0] c);
        @(posedge clk);
        cls <= c;
    endtask
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        // ----------------------------------------
        // reset values and status table
        // ----------------------------------------
        rdc(8'h06, 16'h0001);
        rdc(8'h07, 16'h0002);
        rdc(8'h08, 16'h0003);
        rdc(8'h20, 16'h1388);
        rdc(8'h30, 16'h0000);
        wrr(8'h08, 16'h0000);
        wrr(8'h0C, 16'h0200);
        wrr(8'h0D, 16'h0250);
        wrr(8'h0E, 16'h0100);
        wrr(8'h14, 16'h0200);
        wrr(8'h16, 16'h0300);
        wrr(8'h17, 16'h0100);
        for (int k = 0; k < 14; k++) begin
            wrr(8'h06, {8'h00, TBL[k][63:56]});
            setc(TBL[k]);
            cyc(4);
            chk(16'(ot[0]), 16'h0001);
            chk(16'(ot[2]), 16'h0000);
            if (k == 8) chk(16'(uv), 16'h0001);
            setc(BASE);
            cyc(4);
            chk(16'(ot[0]), 16'h0000);
        end
        @(posedge clk);
        pnl <= 1'b1;
        @(posedge clk);
        pnl <= 1'b0;
        #1;
        chk(16'(frst), 16'h0001);
        $display("test outputs done");
        // ----------------------------------------
        // coast and pid contacts, glitch filter
        // ----------------------------------------
        wrr(8'h00, 16'h0011);
        wrr(8'h03, 16'h0013);
        contact(5'h09);
        cyc(100);
        contact(5'h00);
        cyc(4200);
        chk(16'(coast), 16'h0000);
        contact(5'h09);
        cyc(3990);
        chk(16'(coast), 16'h0000);
        cyc(30);
        chk(16'(coast), 16'h0001);
        chk(16'(pid), 16'h0001);
        contact(5'h00);
        cyc(4030);
        chk(16'(pid), 16'h0000);
        wrr(8'h13, 16'h0001);
        cyc(1);
        chk(16'(pid), 16'h0001);
        wrr(8'h13, 16'h0002);
        cyc(1);
        chk(16'(pid), 16'h0000);
        $display("test contacts done");
        // ----------------------------------------
        // counter pulse and clear
        // ----------------------------------------
        wrr(8'h05, 16'h0017);
        wrr(8'h04, 16'h0018);
        wrr(8'h11, 16'h0001);
        wrr(8'h12, 16'h0001);
        wrr(8'h06, 16'h001B);
        wrr(8'h07, 16'h001C);
        cyc(2);
        chk({13'h0000, ot}, 16'h0000);
        @(posedge clk);
        pls <= 1'b1;
        @(posedge clk);
        pls <= 1'b0;
        cyc(8300);
        rdc(8'h21, 16'h0001);
        chk({13'h0000, ot}, 16'h0003);
        contact(5'h10);
        cyc(4030);
        rdc(8'h21, 16'h0000);
        chk({13'h0000, ot}, 16'h0000);
        contact(5'h00);
        cyc(4030);
        $display("test counter done");
        // ----------------------------------------
        // timer, down trim, restart value
        // ----------------------------------------
        wrr(8'h01, 16'h0015);
        wrr(8'h0F, 16'h0002);
        wrr(8'h08, 16'h000A);
        contact(5'h02);
        cyc(4010);
        chk(16'(ot[2]), 16'h0000);
        cyc(45);
        chk(16'(ot[2]), 16'h0001);
        contact(5'h00);
        cyc(4030);
        chk(16'(ot[2]), 16'h0000);
        wrr(8'h02, 16'h0010);
        wrr(8'h0A, 16'h1380);
        contact(5'h04);
        cyc(4200);
        rdc(8'h20, 16'h1380);
        chk(setf, 16'h1380);
        // ----------------------------------------
        // sequencer, memory clear, winding
        // ----------------------------------------
        wrr(8'h00, 16'h0014);
        wrr(8'h01, 16'h001A);
        wrr(8'h04, 16'h0019);
        wrr(8'h15, 16'h0002);
        wrr(8'h06, 16'h001A);
        wrr(8'h07, 16'h000C);
        wrr(8'h08, 16'h000D);
        setc(TBL[0]);
        contact(5'h03);
        cyc(4030);
        chk({14'h0000, seqr, wen}, 16'h0003);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            ev <= 2'h3;
            @(posedge clk);
            ev <= 2'h0;
            cyc(1);
            chk({12'h000, whold, ot}, k == 1 ? 16'h000F : 16'h000B);
            chk({8'h00, spos}, 16'(k != 1));
        end
        setc(BASE);
        contact(5'h13);
        cyc(4030);
        chk({7'h00, whold, spos}, 16'h0000);
        $display("test sequencer and winding done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rdc(8'h20, 16'h1388);
        $display("test timer and trim done");
        end_of_test();
    end
endmodule
`default_nettype wire
